/* File: verilog/idsx_exec.sv */
// execution slice: skip-on-zero inc/dec, inc, or with file/literal, absolute jump
// assumes fetch presents one word per enabled cycle and the file register
// read data for instr[6:0] is valid combinationally in that same cycle
// and that a write on file_we lands at the edge that ends its cycle
//
// Operation
// - decrement-skip subtracts one, writes destination, flags untouched
// - decrement-skip zero result turns the next instruction into a nop
// - nonzero skip result lets the next instruction run normally
// - increment-skip adds one, writes destination, flags untouched
// - increment-skip zero result turns the next instruction into a nop
// - seven-bit file address; destination bit 0 accumulator, 1 file
// - jump copies upper latch bits 4..3 into program counter 12..11
// - jump takes two cycles and leaves flags untouched
// - or-literal ors accumulator with eight-bit literal, updates null flag
// - increment-file adds one, writes destination, updates null flag
// - or-with-file ors accumulator and file, writes destination, updates flag
`timescale 1ns/100ps
`default_nettype none
`include "idsx_regs.svh"
module idsx_exec (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // fetch side
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    input  wire logic [7:0]  upper_pc_latch,
    // file register read
    input  wire logic [7:0]  file_rdata,
    // file register write
    output logic             file_we,
    output logic [6:0]       file_addr,
    output logic [7:0]       file_wdata,
    // core state
    output logic [7:0]       acc,
    output logic             result_null_flag,
    output logic [12:0]      pc,
    output logic             pc_load,
    output logic             nop_slot
);
    // decoded word class
    idsx_pkg::idsx_op_t    op;
    // control state
    idsx_pkg::idsx_state_t state_r;
    idsx_pkg::idsx_state_t state_nxt;
    // architectural state seen at the ports
    logic [7:0]            acc_r;
    logic [7:0]            acc_nxt;
    logic                  zf_r;
    logic                  zf_nxt;
    logic [12:0]           pc_r;
    logic [12:0]           pc_nxt;
    logic                  pcl_r;
    logic                  pcl_nxt;
    logic                  nop_r;
    logic                  nop_nxt;
    // write port towards the file registers
    logic                  we_r;
    logic                  we_nxt;
    logic [6:0]            wa_r;
    logic [6:0]            wa_nxt;
    logic [7:0]            wd_r;
    logic [7:0]            wd_nxt;
    // datapath helpers
    logic [7:0]            result;
    logic                  to_file;
    logic                  writes;
    logic                  fwd_hit;
    logic [7:0]            file_q;

    idsx_decode u_dec (
        .instr (instr),
        .op    (op)
    );

    // the file write lands one edge after its instruction, so a word that reads the
    // register just written would see stale contents; take the pending data instead
    assign fwd_hit = we_r && (wa_r == instr[6:0]);
    assign file_q  = fwd_hit ? wd_r : file_rdata;

    // shared constants are edited by hand; refuse a set the datapath cannot serve
    // the latch field has to fill exactly pc bits 12..11
    if (`IDSX_LATCH_HI - `IDSX_LATCH_LO != 1) begin : g_latch_chk
        $error("upper latch field must be two bits wide");
    end
    // address takes bits 6..0 and the literal 7..0, so destination must be bit 7
    if (`IDSX_DEST_BIT != 7) begin : g_dest_chk
        $error("destination bit must sit just above the file address");
    end
    // the jump pattern is decoded first and would shadow any opcode inside it
    if ((`IDSX_OP_DEC_SKIP >> 3) == `IDSX_OP_JUMP ||
        (`IDSX_OP_INC_SKIP >> 3) == `IDSX_OP_JUMP ||
        (`IDSX_OP_INC_FILE >> 3) == `IDSX_OP_JUMP ||
        (`IDSX_OP_OR_FILE >> 3) == `IDSX_OP_JUMP ||
        (`IDSX_OP_OR_LIT >> 3) == `IDSX_OP_JUMP) begin : g_op_chk
        $error("an opcode falls inside the jump pattern");
    end

    // one word per valid cycle; decisions are registered so that
    // every port stays a flop output
    always_comb begin
        state_nxt = state_r;
        acc_nxt   = acc_r;
        zf_nxt    = zf_r;
        pc_nxt    = pc_r;
        pcl_nxt   = 1'b0;
        we_nxt    = 1'b0;
        wa_nxt    = wa_r;
        wd_nxt    = wd_r;
        nop_nxt   = 1'b0;
        result    = 8'h00;
        writes    = 1'b0;
        to_file   = instr[`IDSX_DEST_BIT];
        // idle cycles keep a pending flush for the next real word
        if (instr_valid) begin
            case (state_r)
                idsx_pkg::IDSX_ST_FLUSH: begin
                    // the word in this slot is discarded and executed as a nop
                    nop_nxt   = 1'b1;
                    state_nxt = idsx_pkg::IDSX_ST_RUN;
                end
                idsx_pkg::IDSX_ST_RUN: begin
                    case (op)
                        idsx_pkg::IDSX_DEC_SKIP: begin
                            result = file_q - 8'h01;
                            writes = 1'b1;
                            if (result == 8'h00) begin
                                state_nxt = idsx_pkg::IDSX_ST_FLUSH;
                            end
                        end
                        idsx_pkg::IDSX_INC_SKIP: begin
                            result = file_q + 8'h01;
                            writes = 1'b1;
                            if (result == 8'h00) begin
                                state_nxt = idsx_pkg::IDSX_ST_FLUSH;
                            end
                        end
                        idsx_pkg::IDSX_INC_FILE: begin
                            result = file_q + 8'h01;
                            writes = 1'b1;
                            zf_nxt = (result == 8'h00);
                        end
                        idsx_pkg::IDSX_OR_FILE: begin
                            result = acc_r | file_q;
                            writes = 1'b1;
                            zf_nxt = (result == 8'h00);
                        end
                        idsx_pkg::IDSX_OR_LIT: begin
                            // literal form never touches the file registers
                            result  = acc_r | instr[7:0];
                            acc_nxt = result;
                            zf_nxt  = (result == 8'h00);
                        end
                        idsx_pkg::IDSX_JUMP: begin
                            // upper bits come from the latch as it stands this cycle
                            pc_nxt = {upper_pc_latch[`IDSX_LATCH_HI:`IDSX_LATCH_LO],
                                      instr[10:0]};
                            pcl_nxt   = 1'b1;
                            // fetched word behind the jump is stale
                            state_nxt = idsx_pkg::IDSX_ST_FLUSH;
                        end
                        idsx_pkg::IDSX_NONE: begin
                            // words of other slices pass through without effect here
                        end
                        default: begin
                        end
                    endcase
                    // destination 0 leaves the file untouched, so no write pulse
                    if (writes) begin
                        if (to_file) begin
                            we_nxt = 1'b1;
                            wa_nxt = instr[6:0];
                            wd_nxt = result;
                        end else begin
                            acc_nxt = result;
                        end
                    end
                end
                default: state_nxt = idsx_pkg::IDSX_ST_RUN;
            endcase
        end
    end

    // every output leaves straight from this register bank
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= idsx_pkg::IDSX_ST_RUN;
            acc_r   <= `IDSX_ACC_RST;
            zf_r    <= 1'b0;
            pc_r    <= `IDSX_PC_RST;
            pcl_r   <= 1'b0;
            we_r    <= 1'b0;
            wa_r    <= 7'h00;
            wd_r    <= 8'h00;
            nop_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            zf_r    <= zf_nxt;
            pc_r    <= pc_nxt;
            pcl_r   <= pcl_nxt;
            we_r    <= we_nxt;
            wa_r    <= wa_nxt;
            wd_r    <= wd_nxt;
            nop_r   <= nop_nxt;
        end
    end

    // ports are the registers themselves, no logic after the flops
    assign acc              = acc_r;
    assign result_null_flag = zf_r;
    assign pc               = pc_r;
    assign pc_load          = pcl_r;
    assign file_we          = we_r;
    assign file_addr        = wa_r;
    assign file_wdata       = wd_r;
    assign nop_slot         = nop_r;
endmodule
`default_nettype wire

/* File: verilog/idsx_regs.svh */
// constants for the inc/dec-skip, jump and or execution slice
// assumes 14-bit instruction words of the mid-range 8-bit core
`ifndef IDSX_REGS_SVH
`define IDSX_REGS_SVH
// opcode field patterns, instruction bits 13:8
`define IDSX_OP_DEC_SKIP   6'h0b
`define IDSX_OP_INC_SKIP   6'h0f
`define IDSX_OP_INC_FILE   6'h0a
`define IDSX_OP_OR_FILE    6'h04
`define IDSX_OP_OR_LIT     6'h38
// jump uses bits 13:11 only
`define IDSX_OP_JUMP       3'h5
// field positions
`define IDSX_DEST_BIT      7
`define IDSX_LATCH_HI      4
`define IDSX_LATCH_LO      3
// reset values
`define IDSX_ACC_RST       8'h00
`define IDSX_PC_RST        13'h0000
`define IDSX_NOP_WORD      14'h0000
`endif

/* File: verilog/idsx_pkg.sv */
// types shared by the execution slice
// assumes the constants header is included by users
package idsx_pkg;
    typedef enum logic [2:0] {
        IDSX_NONE     = 3'b000,
        IDSX_DEC_SKIP = 3'b001,
        IDSX_INC_SKIP = 3'b010,
        IDSX_INC_FILE = 3'b011,
        IDSX_OR_FILE  = 3'b100,
        IDSX_OR_LIT   = 3'b101,
        IDSX_JUMP     = 3'b110
    } idsx_op_t;
    typedef enum logic [0:0] {
        IDSX_ST_RUN   = 1'b0,
        IDSX_ST_FLUSH = 1'b1
    } idsx_state_t;
endpackage

/* File: verilog/idsx_decode.sv */
// instruction word classifier for the execution slice
// assumes a registered instruction word on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "idsx_regs.svh"
module idsx_decode (
    // instruction word
    input  wire logic [13:0]      instr,
    // classification
    output idsx_pkg::idsx_op_t    op
);
    always_comb begin
        op = idsx_pkg::IDSX_NONE;
        if (instr[13:11] == `IDSX_OP_JUMP) begin
            op = idsx_pkg::IDSX_JUMP;
        end else begin
            case (instr[13:8])
                `IDSX_OP_DEC_SKIP: op = idsx_pkg::IDSX_DEC_SKIP;
                `IDSX_OP_INC_SKIP: op = idsx_pkg::IDSX_INC_SKIP;
                `IDSX_OP_INC_FILE: op = idsx_pkg::IDSX_INC_FILE;
                `IDSX_OP_OR_FILE:  op = idsx_pkg::IDSX_OR_FILE;
                `IDSX_OP_OR_LIT:   op = idsx_pkg::IDSX_OR_LIT;
                default:           op = idsx_pkg::IDSX_NONE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: bench/idsx_exec_assertions.sv */
// port checks on the execution slice
// assumes a bind onto idsx_exec
`timescale 1ns/100ps
`default_nettype none
module idsx_exec_assertions (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // fetch and file side
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0]  upper_pc_latch,
    input wire logic [7:0]  file_rdata,
    // outputs
    input wire logic        file_we,
    input wire logic        result_null_flag,
    input wire logic        pc_load,
    input wire logic        nop_slot,
    input wire logic [6:0]  file_addr,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  acc,
    input wire logic [12:0] pc
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // a discarded word shows as nop_slot, so execute checks allow it
    wire logic [5:0] opc = instr[13:8];
    wire logic       dec_w = instr_valid && opc == 6'h0b;
    wire logic       inc_w = instr_valid && opc == 6'h0f;
    wire logic       jmp_w = instr_valid && instr[13:11] == 3'h5;
    // register contents include a write still pending on the file port
    wire logic [7:0] fval = (file_we && file_addr == instr[6:0]) ? file_wdata : file_rdata;
    dec_write_a: assert property (dec_w && instr[7] |=> nop_slot || file_we &&
        file_addr == $past(instr[6:0]) && file_wdata == $past(fval) - 8'h01) else $error("dec");
    skip_flag_a: assert property (dec_w || inc_w |=> nop_slot || $stable(result_null_flag))
        else $error("skip flag");
    skip_nop_a: assert property ((dec_w && fval == 8'h01 || inc_w && fval == 8'hff)
        ##1 (instr_valid && !nop_slot) |=> nop_slot) else $error("no nop");
    no_skip_a: assert property ((dec_w && fval != 8'h01 || inc_w && fval != 8'hff)
        ##1 (instr_valid && !nop_slot) |=> !nop_slot) else $error("bad nop");
    jump_pc_a: assert property (jmp_w |=> nop_slot || pc_load && $stable(result_null_flag) &&
        pc == {$past(upper_pc_latch[4:3]), $past(instr[10:0])}) else $error("jump pc");
    jump_flush_a: assert property (jmp_w ##1 (instr_valid && !nop_slot) |=> nop_slot &&
        !pc_load && !file_we && $stable(acc)) else $error("jump flush");
    or_lit_a: assert property (instr_valid && opc == 6'h38 |=> nop_slot ||
        acc == ($past(acc) | $past(instr[7:0])) && result_null_flag == (acc == 8'h00)) else $error("or");
    inc_file_a: assert property (instr_valid && opc == 6'h0a && instr[7] |=> nop_slot ||
        file_wdata == $past(fval) + 8'h01 && result_null_flag == (file_wdata == 8'h00))
        else $error("inc");
    cover property (dec_w ##1 nop_slot);
    cover property (inc_w ##1 nop_slot);
    cover property (jmp_w ##1 pc_load);
    cover property (file_we && instr_valid && opc == 6'h0a && file_addr == instr[6:0]);
endmodule
bind idsx_exec idsx_exec_assertions CHK (.sys_clk, .nrst, .instr_valid, .instr, .upper_pc_latch,
    .file_rdata, .file_we, .result_null_flag, .pc_load, .nop_slot, .file_addr, .file_wdata, .acc, .pc);
`default_nettype wire

/* File: bench/idsx_file_model.sv */
// file register array behind the slice
// assumes read at the presented address, write on the edge
`timescale 1ns/100ps
`default_nettype none
module idsx_file_model (
    // clock
    input  wire logic       sys_clk,
    // write port from the slice
    input  wire logic       file_we,
    input  wire logic [6:0] file_addr,
    input  wire logic [7:0] file_wdata,
    // read port at the address that fetch presents
    input  wire logic [6:0] rd_addr,
    output logic      [7:0] file_rdata
);
    logic [7:0] mem [128];
    assign file_rdata = mem[rd_addr];
    // writes land on the edge, so a read in the same cycle still sees the old value
    always @(posedge sys_clk) begin
        if (file_we) begin
            mem[file_addr] <= file_wdata;
        end
    end
endmodule
`default_nettype wire

/* File: bench/idsx_exec_tb.sv */
// self-checking bench for the execution slice
// assumes the file model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module idsx_exec_tb;
    logic        sys_clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0]  upper_pc_latch = 8'h00, file_rdata, file_wdata, acc;
    logic        file_we, result_null_flag, pc_load, nop_slot;
    logic [6:0]  file_addr;
    logic [12:0] pc;
    int          fails = 0, checks_done = 0;
    idsx_exec DUT (.sys_clk, .nrst, .instr_valid, .instr, .upper_pc_latch, .file_rdata, .file_we,
        .file_addr, .file_wdata, .acc, .result_null_flag, .pc, .pc_load, .nop_slot);
    idsx_file_model FM (.sys_clk, .file_we, .rd_addr(instr[6:0]), .file_addr, .file_wdata,
        .file_rdata);
    initial forever #20 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // words are driven just after an edge and taken at the next one
    task automatic ex(input logic [13:0] w);
        instr = w;
        instr_valid = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic s_dec_skip;
        FM.mem[5] = 8'h01;
        ex(14'h0b85);
        chk({file_we, file_addr, file_wdata, result_null_flag}, 17'h10a00);
        ex(14'h3801);
        chk({nop_slot, acc}, 9'h100);
    endtask
    task automatic s_no_skip;
        ex(14'h3800);
        chk({acc, result_null_flag}, 9'h001);
        FM.mem[7] = 8'h02;
        ex(14'h0b07);
        chk({file_we, acc, result_null_flag}, 10'h003);
        ex(14'h3802);
        chk({nop_slot, acc, result_null_flag}, 10'h006);
    endtask
    task automatic s_inc_skip;
        FM.mem[6] = 8'hff;
        ex(14'h0f06);
        chk({file_we, acc, result_null_flag}, 10'h000);
        ex(14'h38fe);
        chk({nop_slot, acc}, 9'h100);
    endtask
    task automatic s_inc_or_file;
        FM.mem[8] = 8'hff;
        FM.mem[9] = 8'h80;
        ex(14'h0a88);
        chk({file_we, file_addr, file_wdata, result_null_flag}, 17'h11001);
        ex(14'h0a08);
        chk({acc, result_null_flag}, 9'h002);
        ex(14'h0489);
        chk({file_we, file_wdata, acc}, 17'h18101);
    endtask
    task automatic s_jump;
        upper_pc_latch = 8'h18;
        ex(14'h2d55);
        chk({pc_load, pc, result_null_flag}, 15'h7aaa);
        ex(14'h38fe);
        chk({nop_slot, pc_load, acc}, 10'h201);
        instr_valid = 1'b0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        s_dec_skip();
        s_no_skip();
        s_inc_skip();
        s_inc_or_file();
        s_jump();
        repeat (2) @(posedge sys_clk);
        conclude();
    end
endmodule
`default_nettype wire
